/* verilog/cns_defs.vh */
// Offsets, field positions, reset values and timing counts of the tuning status bank
`ifndef CNS_DEFS_VH
`define CNS_DEFS_VH

`define CNS_ADDR_W 5
`define CNS_DATA_W 24

`define CNS_OFS_TUNING_STROBE 5'h04
`define CNS_OFS_TUNING_STATUS 5'h08
`define CNS_OFS_TUNING_RAW_COUNT 5'h09
`define CNS_OFS_NV_SETTINGS_IMAGE 5'h0A
`define CNS_OFS_NV_PROGRAM_ENABLE 5'h0B
`define CNS_OFS_NV_BIT_INDEX 5'h0C
`define CNS_OFS_NV_PROGRAM_STROBE 5'h0D
`define CNS_OFS_SELFTEST_ENABLE 5'h0E
`define CNS_OFS_SELFTEST_RESULT 5'h0F
`define CNS_OFS_WINDOW_FIRST 5'h10
`define CNS_OFS_WINDOW_LAST 5'h1A

`define CNS_ST_CAL_BUSY 4
`define CNS_ST_NV_BUSY 5
`define CNS_IMG_FLAG 13
`define CNS_IMG_COARSE_MSB 14
`define CNS_IMG_W 16
`define CNS_SIG_BUSY 16
`define CNS_SIG_W 16

`define CNS_FINE_MAX 4'hB
`define CNS_FINE_RESET 4'h0
`define CNS_SIG_RESET 16'h0000
`define CNS_IMG_RESET 16'h0000
`define CNS_INDEX_RESET 4'h0
`define CNS_CRC_POLY 16'h1021
`define CNS_CRC_SEED 16'hFFFF

`define CNS_ADJ_STEP_PS 1024
`define CNS_ADJ_SHIFT 10
`define CNS_FINE_SHIFT 11
`define CNS_SUM_W 26

`define CNS_CLK_PERIOD_NS 10
`define CNS_NV_BURN_TIME_NS 100000
`define CNS_SELFTEST_LEN 256
`define CNS_TIMER_W 16

`endif

/* verilog/cns_crc16.v */
// Bit-serial CRC-16 signature register used by the tuning engine self test
`timescale 1ns/1ns
`include "cns_defs.vh"

module cns_crc16 (
    input wire clk_in,
    input wire srst_in,
    input wire clear_in,
    input wire shift_in,
    input wire data_in,
    output reg [15:0] crc_out
);

    localparam [15:0] POLY = `CNS_CRC_POLY;

    wire fb;
    wire [15:0] crc_nxt;

    assign fb = crc_out[15] ^ data_in;
    assign crc_nxt[0] = fb;

    genvar i;
    generate
        for (i = 1; i < 16; i = i + 1) begin : g_bit
            assign crc_nxt[i] = crc_out[i-1] ^ (POLY[i] & fb);
        end
    endgenerate

    always @(posedge clk_in) begin
        if (srst_in) begin
            crc_out <= `CNS_SIG_RESET;
        end else if (clear_in) begin
            crc_out <= `CNS_CRC_SEED;
        end else if (shift_in) begin
            crc_out <= crc_nxt;
        end
    end

endmodule

/* verilog/cns_tuning_status_regs.v */
// Tuning status, nonvolatile settings image and burn control, and self-test registers
`timescale 1ns/1ns
`include "cns_defs.vh"

module cns_tuning_status_regs #(
    parameter NV_BURN_CYCLES =
        (`CNS_NV_BURN_TIME_NS + `CNS_CLK_PERIOD_NS - 1) / `CNS_CLK_PERIOD_NS
) (
    input wire clk_in,
    input wire srst_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [4:0] reg_addr_in,
    input wire [23:0] reg_wdata_in,
    output reg [23:0] reg_rdata_out,
    output reg reg_rvalid_out,
    input wire [8:0] meas_adj_in,
    input wire [9:0] settings_in,
    input wire cal_done_in,
    input wire [23:0] cal_count_in,
    output reg cal_start_out,
    output wire selftest_mode_out,
    output reg nv_burn_pulse_out,
    output reg [3:0] nv_burn_addr_out,
    output wire nv_burn_in_progress_out,
    output reg [9:0] eff_settings_out,
    output reg [3:0] stored_fine_code_out,
    output reg ctrl_bit0_force_out
);

    // Counts are worked out as integers and cut to the timer width on purpose
    localparam integer BURN_LAST_INT = NV_BURN_CYCLES - 1;
    localparam integer SELFTEST_LAST_INT = `CNS_SELFTEST_LEN - 1;
    localparam [`CNS_TIMER_W-1:0] BURN_LAST = BURN_LAST_INT[`CNS_TIMER_W-1:0];
    localparam [`CNS_TIMER_W-1:0] SELFTEST_LAST = SELFTEST_LAST_INT[`CNS_TIMER_W-1:0];
    localparam [`CNS_TIMER_W-1:0] TIMER_ZERO = 16'h0000;

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_CAL = 2'b01;
    localparam [1:0] ST_SELFTEST = 2'b10;
    localparam [1:0] ST_BURN = 2'b11;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`CNS_TIMER_W-1:0] timer_r;
    reg [`CNS_TIMER_W-1:0] timer_nxt;
    reg [3:0] fine_code_r;
    reg [23:0] raw_count_r;
    reg [`CNS_IMG_W-1:0] nv_image_r;
    reg nv_burn_enable_r;
    reg [3:0] nv_bit_index_r;
    reg selftest_mode_enable_r;
    reg selftest_running_r;
    reg [15:0] selftest_signature_r;

    wire wr_cal_strobe;
    wire wr_burn_strobe;
    wire crc_clear;
    wire crc_shift;
    wire crc_data;
    wire [15:0] crc_value;
    wire programmed_flag;
    wire seq_idle;
    wire start_cal;
    wire start_selftest;
    wire start_burn;
    wire cal_busy;
    wire burn_busy;
    wire [23:0] status_word;
    wire [23:0] image_word;
    wire [23:0] result_word;

    // Correction offset scaled to picoseconds and added to the raw count
    wire signed [`CNS_SUM_W-1:0] count_ext;
    wire signed [`CNS_SUM_W-1:0] adj_ps;
    wire signed [`CNS_SUM_W-1:0] adj_sum;
    wire [`CNS_SUM_W-1:0] sum_steps;
    reg [3:0] fine_decoded;

    assign wr_cal_strobe = reg_wr_in && (reg_addr_in == `CNS_OFS_TUNING_STROBE);
    assign wr_burn_strobe = reg_wr_in && (reg_addr_in == `CNS_OFS_NV_PROGRAM_STROBE);
    assign programmed_flag = nv_image_r[`CNS_IMG_FLAG];

    // Starts are decoded once and taken only while the sequencer is idle
    assign seq_idle = (state_r == ST_IDLE);
    assign start_cal = seq_idle && (state_nxt == ST_CAL);
    assign start_selftest = seq_idle && (state_nxt == ST_SELFTEST);
    assign start_burn = seq_idle && (state_nxt == ST_BURN);
    assign cal_busy = (state_r == ST_CAL);
    assign burn_busy = (state_r == ST_BURN);

    assign count_ext = {2'b00, cal_count_in};
    assign adj_ps = {{(`CNS_SUM_W - 9 - `CNS_ADJ_SHIFT){meas_adj_in[8]}}, meas_adj_in,
                     {`CNS_ADJ_SHIFT{1'b0}}};
    assign adj_sum = count_ext + adj_ps;
    assign sum_steps = $unsigned(adj_sum) >> `CNS_FINE_SHIFT;

    // Negative sums clamp to the lowest code, large ones to the highest
    always @* begin
        if (adj_sum[`CNS_SUM_W-1]) begin
            fine_decoded = `CNS_FINE_RESET;
        end else if (sum_steps > {{(`CNS_SUM_W - 4){1'b0}}, `CNS_FINE_MAX}) begin
            fine_decoded = `CNS_FINE_MAX;
        end else begin
            fine_decoded = sum_steps[3:0];
        end
    end

    // Sequencer shared by calibration, self test and bit burning
    always @* begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        case (state_r)
            ST_IDLE: begin
                if (wr_cal_strobe && selftest_mode_enable_r) begin
                    state_nxt = ST_SELFTEST;
                    timer_nxt = SELFTEST_LAST;
                end else if (wr_cal_strobe) begin
                    state_nxt = ST_CAL;
                end else if (wr_burn_strobe && nv_burn_enable_r) begin
                    state_nxt = ST_BURN;
                    timer_nxt = BURN_LAST;
                end
            end
            ST_CAL: begin
                if (cal_done_in) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SELFTEST, ST_BURN: begin
                if (timer_r == TIMER_ZERO) begin
                    state_nxt = ST_IDLE;
                end else begin
                    timer_nxt = timer_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                timer_nxt = TIMER_ZERO;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
            timer_r <= TIMER_ZERO;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // Self-test feeds counter bits mixed with the run timer into the signature
    assign crc_clear = start_selftest;
    assign crc_shift = (state_r == ST_SELFTEST);
    assign crc_data = ^cal_count_in ^ timer_r[0];

    cns_crc16 u_crc (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .clear_in(crc_clear),
        .shift_in(crc_shift),
        .data_in(crc_data),
        .crc_out(crc_value)
    );

    always @(posedge clk_in) begin
        if (srst_in) begin
            selftest_running_r <= 1'b0;
            selftest_signature_r <= `CNS_SIG_RESET;
        end else if (crc_clear) begin
            selftest_running_r <= 1'b1;
        end else if (crc_shift && (timer_r == TIMER_ZERO)) begin
            selftest_running_r <= 1'b0;
            selftest_signature_r <= crc_nxt_final(crc_value, crc_data);
        end
    end

    // Last shift folded in so the stored signature covers every bit of the run
    function [15:0] crc_nxt_final;
        input [15:0] crc;
        input din;
        reg fb;
        begin
            fb = crc[15] ^ din;
            crc_nxt_final = {crc[14:0], 1'b0} ^ ({16{fb}} & `CNS_CRC_POLY);
        end
    endfunction

    // Calibration result capture
    always @(posedge clk_in) begin
        if (srst_in) begin
            fine_code_r <= `CNS_FINE_RESET;
            raw_count_r <= 24'h000000;
        end else if ((state_r == ST_CAL) && cal_done_in) begin
            fine_code_r <= fine_decoded;
            raw_count_r <= cal_count_in;
        end
    end

    // Host-writable control registers
    always @(posedge clk_in) begin
        if (srst_in) begin
            nv_burn_enable_r <= 1'b0;
            nv_bit_index_r <= `CNS_INDEX_RESET;
            selftest_mode_enable_r <= 1'b0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `CNS_OFS_NV_PROGRAM_ENABLE: nv_burn_enable_r <= reg_wdata_in[0];
                `CNS_OFS_NV_BIT_INDEX: nv_bit_index_r <= reg_wdata_in[3:0];
                `CNS_OFS_SELFTEST_ENABLE: selftest_mode_enable_r <= reg_wdata_in[0];
                default: begin
                end
            endcase
        end
    end

    // Burned bits go from 0 to 1 on a burn and back to 0 only on reset; the store reads all zero when blank
    always @(posedge clk_in) begin
        if (srst_in) begin
            nv_image_r <= `CNS_IMG_RESET;
            nv_burn_pulse_out <= 1'b0;
            nv_burn_addr_out <= `CNS_INDEX_RESET;
        end else begin
            nv_burn_pulse_out <= start_burn;
            if (start_burn) begin
                nv_burn_addr_out <= nv_bit_index_r;
                nv_image_r[nv_bit_index_r] <= 1'b1;
            end
        end
    end

    assign nv_burn_in_progress_out = burn_busy;
    assign selftest_mode_out = selftest_mode_enable_r;

    // Effective settings: stored values win only once the programmed flag is burned
    always @(posedge clk_in) begin
        if (srst_in) begin
            eff_settings_out <= 10'h000;
            stored_fine_code_out <= `CNS_FINE_RESET;
            ctrl_bit0_force_out <= 1'b1;
            cal_start_out <= 1'b0;
        end else begin
            cal_start_out <= start_cal;
            ctrl_bit0_force_out <= ~programmed_flag;
            stored_fine_code_out <= nv_image_r[3:0];
            if (programmed_flag) begin
                eff_settings_out <= {nv_image_r[`CNS_IMG_COARSE_MSB], nv_image_r[6:4],
                                     nv_image_r[8], nv_image_r[7],
                                     nv_image_r[12:11], nv_image_r[10:9]};
            end else begin
                eff_settings_out <= settings_in;
            end
        end
    end

    // Read words assembled field by field; unused high bits read zero
    assign status_word = {18'h00000, burn_busy, cal_busy, fine_code_r};
    assign image_word = {8'h00, 1'b0, nv_image_r[14:0]};
    assign result_word = {7'h00, selftest_running_r, selftest_signature_r};

    // Read port: data one cycle after the request, unmapped and reserved words read zero
    always @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 24'h000000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `CNS_OFS_TUNING_STATUS: reg_rdata_out <= status_word;
                    `CNS_OFS_TUNING_RAW_COUNT: reg_rdata_out <= raw_count_r;
                    `CNS_OFS_NV_SETTINGS_IMAGE: reg_rdata_out <= image_word;
                    `CNS_OFS_NV_PROGRAM_ENABLE: reg_rdata_out <= {23'h000000, nv_burn_enable_r};
                    `CNS_OFS_NV_BIT_INDEX: reg_rdata_out <= {20'h00000, nv_bit_index_r};
                    `CNS_OFS_SELFTEST_ENABLE: reg_rdata_out <= {23'h000000,
                        selftest_mode_enable_r};
                    `CNS_OFS_SELFTEST_RESULT: reg_rdata_out <= result_word;
                    default: reg_rdata_out <= 24'h000000;
                endcase
            end
        end
    end

endmodule

/* bench/cns_tuning_status_regs_sva.sv */
// Port-level concurrent checks for the tuning status bank
`timescale 1ns/1ns
module cns_regs_sva #(
    parameter NV_BURN_CYCLES = 8
) (
    input wire clk_in,
    input wire srst_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [4:0] reg_addr_in,
    input wire [23:0] reg_wdata_in,
    input wire [23:0] reg_rdata_out,
    input wire reg_rvalid_out,
    input wire [8:0] meas_adj_in,
    input wire [9:0] settings_in,
    input wire cal_done_in,
    input wire [23:0] cal_count_in,
    input wire cal_start_out,
    input wire selftest_mode_out,
    input wire nv_burn_pulse_out,
    input wire [3:0] nv_burn_addr_out,
    input wire nv_burn_in_progress_out,
    input wire [9:0] eff_settings_out,
    input wire [3:0] stored_fine_code_out,
    input wire ctrl_bit0_force_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // Length of the current burn busy run
    reg [15:0] burn_cnt_r;
    always @(posedge clk_in) begin
        if (srst_in || !nv_burn_in_progress_out)
            burn_cnt_r <= 16'h0000;
        else
            burn_cnt_r <= burn_cnt_r + 16'h0001;
    end
    sequence s_burn_req;
        reg_wr_in && reg_addr_in == 5'h0D ##1 nv_burn_pulse_out;
    endsequence
    chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read got no answer");
    chk_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("answer without read");
    chk_cal_start_cause: assert property (cal_start_out |->
        $past(reg_wr_in && reg_addr_in == 5'h04 && !selftest_mode_out))
        else $error("calibration start without strobe");
    chk_burn_cause: assert property (nv_burn_pulse_out |->
        $past(reg_wr_in && reg_addr_in == 5'h0D))
        else $error("burn pulse without strobe");
    chk_burn_busy_on: assert property (s_burn_req |-> nv_burn_in_progress_out)
        else $error("burn busy not raised");
    chk_burn_busy_len: assert property ($fell(nv_burn_in_progress_out) |->
        burn_cnt_r == NV_BURN_CYCLES)
        else $error("burn busy length wrong");
    chk_burn_single: assert property (nv_burn_pulse_out |=> !nv_burn_pulse_out [*7])
        else $error("burn pulse repeated");
    chk_flag_release: assert property ($fell(ctrl_bit0_force_out) |->
        $past(nv_burn_pulse_out) && $past(nv_burn_addr_out) == 4'hD)
        else $error("override released without flag burn");
    chk_mode_cause: assert property ($changed(selftest_mode_out) |->
        $past(reg_wr_in && reg_addr_in == 5'h0E))
        else $error("self-test mode changed without write");
    cover property (s_burn_req);
endmodule

bind cns_tuning_status_regs cns_regs_sva #(.NV_BURN_CYCLES(NV_BURN_CYCLES)) u_sva (
    .clk_in(clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .meas_adj_in(meas_adj_in), .settings_in(settings_in),
    .cal_done_in(cal_done_in), .cal_count_in(cal_count_in), .cal_start_out(cal_start_out),
    .selftest_mode_out(selftest_mode_out), .nv_burn_pulse_out(nv_burn_pulse_out),
    .nv_burn_addr_out(nv_burn_addr_out), .nv_burn_in_progress_out(nv_burn_in_progress_out),
    .eff_settings_out(eff_settings_out), .stored_fine_code_out(stored_fine_code_out),
    .ctrl_bit0_force_out(ctrl_bit0_force_out));

/* bench/cns_tuning_engine_model.sv */
// Behavioural tuning engine that answers calibration starts
`timescale 1ns/1ns
module cns_tuning_engine_model (
    input wire clk_in,
    input wire srst_in,
    input wire start_in,
    input wire [7:0] delay_in,
    input wire [23:0] count_set_in,
    output reg done_out = 1'b0,
    output reg [23:0] count_out = 24'h000000
);
    reg busy_r = 1'b0;
    reg [7:0] wait_r = 8'h00;
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        // Count is only valid with done, so it toggles otherwise
        count_out <= ~count_out;
        if (srst_in) begin
            busy_r <= 1'b0;
        end else if (start_in) begin
            busy_r <= 1'b1;
            wait_r <= delay_in;
        end else if (busy_r && wait_r == 8'h00) begin
            done_out <= 1'b1;
            count_out <= count_set_in;
            busy_r <= 1'b0;
        end else if (busy_r) begin
            wait_r <= wait_r - 8'h01;
        end
    end
endmodule

/* bench/cns_tuning_status_regs_test.sv */
// Self-checking bench for the tuning status bank
`timescale 1ns/1ns
`define TB_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end
module cns_tuning_status_regs_test;
    reg clk_in = 0, srst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    reg [4:0] reg_addr_in = 0;
    reg [23:0] reg_wdata_in = 0, count_set = 0;
    reg [8:0] meas_adj_in = 0;
    reg [9:0] settings_in = 10'h3FF;
    reg [7:0] delay = 0;
    wire [23:0] reg_rdata_out, cal_count_in;
    wire reg_rvalid_out, cal_done_in, cal_start_out, selftest_mode_out, nv_burn_pulse_out;
    wire nv_burn_in_progress_out, ctrl_bit0_force_out;
    wire [3:0] nv_burn_addr_out, stored_fine_code_out;
    wire [9:0] eff_settings_out;
    integer n_fail = 0, checks_done = 0, cyc = 0;
    cns_tuning_status_regs #(.NV_BURN_CYCLES(8)) u_dut (.clk_in(clk_in), .srst_in(srst_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .meas_adj_in(meas_adj_in), .settings_in(settings_in),
        .cal_done_in(cal_done_in), .cal_count_in(cal_count_in), .cal_start_out(cal_start_out),
        .selftest_mode_out(selftest_mode_out), .nv_burn_pulse_out(nv_burn_pulse_out),
        .nv_burn_addr_out(nv_burn_addr_out), .nv_burn_in_progress_out(nv_burn_in_progress_out),
        .eff_settings_out(eff_settings_out), .stored_fine_code_out(stored_fine_code_out),
        .ctrl_bit0_force_out(ctrl_bit0_force_out));
    cns_tuning_engine_model u_eng (.clk_in(clk_in), .srst_in(srst_in), .start_in(cal_start_out),
        .delay_in(delay), .count_set_in(count_set), .done_out(cal_done_in),
        .count_out(cal_count_in));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("checks %0d failures %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task wr(input [4:0] a, input [23:0] d);
        begin
            @(posedge clk_in);
            #1 reg_wr_in = 1;
            reg_addr_in = a;
            reg_wdata_in = d;
            @(posedge clk_in);
            #1 reg_wr_in = 0;
        end
    endtask
    // Read data is forced unknown when no answer came
    task rd(input [4:0] a, output [23:0] d);
        begin
            @(posedge clk_in);
            #1 reg_rd_in = 1;
            reg_addr_in = a;
            @(posedge clk_in);
            #1 reg_rd_in = 0;
            d = (reg_rvalid_out === 1'b1) ? reg_rdata_out : 24'hXXXXXX;
        end
    endtask
    task rdm(input [4:0] a, input [23:0] m, input [23:0] e);
        reg [23:0] d;
        begin
            rd(a, d);
            `TB_CHK(d & m, e)
        end
    endtask
    task poll;
        reg [23:0] d;
        integer i;
        begin
            d = 24'h30;
            for (i = 0; i < 100 && d[5:4] != 2'b00; i++) rd(5'h08, d);
            `TB_CHK(d[5:4], 2'b00)
        end
    endtask
    task t_reset;
        begin
            rdm(5'h0B, 24'hFFFFFF, 24'h0);
            rdm(5'h0C, 24'hFFFFFF, 24'h0);
            rdm(5'h0E, 24'hFFFFFF, 24'h0);
            rdm(5'h0F, 24'hFFFFFF, 24'h0);
            wr(5'h0A, 24'hFFFFFF);
            rdm(5'h0A, 24'hFFFFFF, 24'h0);
            `TB_CHK({ctrl_bit0_force_out, eff_settings_out}, {1'b1, settings_in})
        end
    endtask
    task t_cal(input [23:0] cnt, input [8:0] adj, input [7:0] dly);
        integer s;
        begin
            count_set = cnt;
            meas_adj_in = adj;
            delay = dly;
            s = cnt;
            s = s + $signed(adj) * 1024;
            s = (s < 0) ? 0 : s / 2048;
            if (s > 11) s = 11;
            wr(5'h04, 24'h0);
            `TB_CHK(cal_start_out, 1'b1)
            rdm(5'h08, 24'h10, 24'h10);
            poll;
            rdm(5'h08, 24'hFFFFFF, s[23:0]);
            rdm(5'h09, 24'hFFFFFF, cnt);
        end
    endtask
    task burn(input [3:0] idx);
        begin
            wr(5'h0C, {20'h0, idx});
            rdm(5'h0C, 24'hFFFFFF, {20'h0, idx});
            wr(5'h0D, 24'h0);
            `TB_CHK({nv_burn_pulse_out, nv_burn_addr_out}, {1'b1, idx})
            wr(5'h0D, 24'h0);
            `TB_CHK(nv_burn_pulse_out, 1'b0)
            poll;
        end
    endtask
    task t_burn;
        begin
            wr(5'h0D, 24'h0);
            `TB_CHK(nv_burn_pulse_out, 1'b0)
            wr(5'h0B, 24'h1);
            rdm(5'h0B, 24'hFFFFFF, 24'h1);
            burn(4'h7);
            burn(4'hE);
            burn(4'h2);
            `TB_CHK({ctrl_bit0_force_out, eff_settings_out}, {1'b1, settings_in})
            burn(4'hD);
            rdm(5'h0A, 24'hFFFFFF, 24'h6084);
            `TB_CHK(stored_fine_code_out, 4'h4)
            `TB_CHK({ctrl_bit0_force_out, eff_settings_out}, {1'b0, 10'h210})
        end
    endtask
    task t_selftest;
        reg [15:0] c;
        reg fb;
        integer k;
        begin
            // Reference signature: seed, one shift per run cycle, timer counting down to zero
            c = 16'hFFFF;
            for (k = 255; k >= 0; k--) begin
                fb = c[15] ^ (^count_set) ^ k[0];
                c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
            end
            wr(5'h0E, 24'h1);
            `TB_CHK(selftest_mode_out, 1'b1)
            wr(5'h04, 24'h0);
            `TB_CHK(cal_start_out, 1'b0)
            rdm(5'h0F, 24'h10000, 24'h10000);
            repeat (260) @(posedge clk_in);
            rdm(5'h0F, 24'h10000, 24'h0);
            rdm(5'h0F, 24'hFFFFFF, {8'h00, c});
            wr(5'h0E, 24'h0);
        end
    endtask
    // Reset in mid-run must clear results, controls and the burned image again
    task t_rerst;
        begin
            @(posedge clk_in);
            #1 srst_in = 1;
            repeat (2) @(posedge clk_in);
            #1 srst_in = 0;
            t_reset;
            rdm(5'h08, 24'hFFFFFF, 24'h0);
            rdm(5'h09, 24'hFFFFFF, 24'h0);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        #1 srst_in = 0;
        t_reset;
        t_cal(24'd12000, 9'h000, 8'd0);
        t_cal(24'd12000, 9'h1EC, 8'd40);
        t_cal(24'd30000, 9'h005, 8'd3);
        t_cal(24'd23500, 9'h1FF, 8'd7);
        t_burn;
        t_selftest;
        t_rerst;
        give_verdict;
    end
endmodule
